// *** inc/eag_pkg.sv ***
// Register map, field positions and helpers for the error aggregator
package eag_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 16;
    localparam int QID_W = 12;
    localparam int PAR_W = 8;

    localparam logic [15:0] OFS_ECC_SB_MASK = 16'h00f0;
    localparam logic [15:0] OFS_ECC_SB_STATUS = 16'h00f4;
    localparam logic [15:0] OFS_ECC_DB_MASK = 16'h00f8;
    localparam logic [15:0] OFS_ECC_DB_STATUS = 16'h00fc;
    localparam logic [15:0] OFS_CENTRAL_STATUS = 16'h0248;
    localparam logic [15:0] OFS_CENTRAL_MASK = 16'h024c;
    localparam logic [15:0] OFS_RQ_STATUS = 16'h0260;
    localparam logic [15:0] OFS_RQ_MASK = 16'h0264;
    localparam logic [15:0] OFS_RQ_LOG = 16'h0268;
    localparam logic [15:0] OFS_ERR_INT_CTRL = 16'h02b0;
    localparam logic [15:0] OFS_STREAM_STATUS = 16'h0af0;
    localparam logic [15:0] OFS_STREAM_MASK = 16'h0af4;
    localparam logic [15:0] OFS_FATAL_STATUS = 16'h0af8;
    localparam logic [15:0] OFS_FATAL_MASK = 16'h0afc;
    localparam logic [15:0] OFS_FATAL_ENABLE = 16'h0b00;
    localparam logic [15:0] OFS_FIRST_QID = 16'h0b30;
    localparam logic [15:0] OFS_MM_C2H_STATUS = 16'h1040;
    localparam logic [15:0] OFS_MM_C2H_CODE = 16'h1058;
    localparam logic [15:0] OFS_MM_C2H_INFO = 16'h105c;
    localparam logic [15:0] OFS_MM_H2C_STATUS = 16'h1240;
    localparam logic [15:0] OFS_MM_H2C_CODE = 16'h1258;
    localparam logic [15:0] OFS_MM_H2C_INFO = 16'h125c;

    localparam int LEAF_ECC_SB = 0;
    localparam int LEAF_ECC_DB = 1;
    localparam int LEAF_RQ = 2;
    localparam int LEAF_STREAM = 3;
    localparam int LEAF_MM_C2H = 4;
    localparam int LEAF_MM_H2C = 5;

    localparam logic [31:0] ECC_VALID = 32'h7fff_fe11;
    localparam logic [31:0] ECC_BRIDGE_SLAVE = 32'h0000_1800;
    localparam logic [31:0] ALL_VALID = 32'hffff_ffff;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [31:0] C2H_WR_CODES = 32'h0000_0007;
    localparam logic [31:0] C2H_RD_CODES = 32'h0000_0003;
    localparam logic [31:0] H2C_WR_CODES = 32'h0000_0003;
    localparam logic [31:0] H2C_RD_CODES = 32'h0041_013e;

    localparam int MM_DIR_BIT = 16;
    localparam int MM_CODE_MSB = 15;
    localparam int MM_QID_MSB = 28;
    localparam int MM_QID_LSB = 17;
    localparam int MM_CIDX_MSB = 15;
    localparam int FATAL_STOP_BIT = 0;
    localparam int FATAL_PARITY_BIT = 1;
    localparam int ARM_BIT = 0;

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] bm;
        for (int i = 0; i < 4; i++) begin
            bm[8*i +: 8] = {8{sel[i]}};
        end
        return bm;
    endfunction

    function automatic logic [31:0] mm_code(input logic wr, input logic [31:0] code,
                                            input logic [31:0] wrOk, input logic [31:0] rdOk);
        return code & (wr ? wrOk : rdOk);
    endfunction

    function automatic logic [31:0] mm_info(input logic [11:0] qid, input logic dir,
                                            input logic [15:0] cidx);
        return {3'h0, qid, dir, cidx};
    endfunction
endpackage

// *** inc/eag_leaf_if.sv ***
// Signals between the register block and one leaf aggregator
`timescale 1ns/1ps
interface eag_leaf_if #(parameter int W = 32);
    logic [W-1:0] errEvent;
    logic [W-1:0] clearBits;
    logic [W-1:0] maskData;
    logic maskWe;
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic forward;
    modport leaf(
        input errEvent,
        input clearBits,
        input maskData,
        input maskWe,
        output status,
        output mask,
        output forward
    );
    modport owner(
        output errEvent,
        output clearBits,
        output maskData,
        output maskWe,
        input status,
        input mask,
        input forward
    );
endinterface

// *** hw/eag_leaf.sv ***
// Leaf aggregator: sticky status with write-one-to-clear and forwarding mask
`timescale 1ns/1ps
module eag_leaf #(
    parameter int W = 32,
    parameter logic [31:0] VALID = 32'hffff_ffff
) (
    input wire logic core_clk,
    input wire logic reset,
    eag_leaf_if.leaf lp
);
    // Status survives reset; only the power-up value defines it
    logic [W-1:0] status = '0;
    logic [W-1:0] mask;
    logic forward;
    logic [W-1:0] next_status;
    logic [W-1:0] next_mask;
    logic next_forward;
    logic [W-1:0] evD = '0;
    logic [W-1:0] clrD = '0;

    always_comb begin
        // Event beats a clear in the same cycle
        next_status = (status & ~lp.clearBits) | (lp.errEvent & VALID[W-1:0]);
        next_mask = lp.maskWe ? (lp.maskData & VALID[W-1:0]) : mask;
        next_forward = |(status & mask);
    end

    always_ff @(posedge core_clk) begin
        status <= next_status;
        evD <= lp.errEvent & VALID[W-1:0];
        clrD <= lp.clearBits & ~lp.errEvent;
        if (reset) begin
            mask <= '0;
            forward <= 1'b0;
        end else begin
            mask <= next_mask;
            forward <= next_forward;
        end
    end

    assign lp.status = status;
    assign lp.mask = mask;
    assign lp.forward = forward;

    property p_leaf_logged;
        @(posedge core_clk) disable iff (reset) (status & evD) == evD;
    endproperty
    a_leaf_logged: assert property (p_leaf_logged) else $error("leaf event lost");

    property p_leaf_clear;
        @(posedge core_clk) disable iff (reset) (status & clrD) == '0;
    endproperty
    a_leaf_clear: assert property (p_leaf_clear) else $error("leaf clear ignored");

    property p_leaf_block;
        @(posedge core_clk) disable iff (reset)
            ((status & mask) == '0) [*2] |-> !forward;
    endproperty
    a_leaf_block: assert property (p_leaf_block) else $error("masked leaf forwarded");
endmodule

// *** hw/eag_error_aggregator.sv ***
// Error aggregator: leaves, central status, error interrupt and fatal handling
`timescale 1ns/1ps
// Notes on behaviour
// - Each leaf logs its own errors; all but the fatal leaf forward them to one central aggregator.
// - Central status has one bit per leaf except the fatal leaf, naming where an error sits.
// - Central mask bit set lets that leaf error reach the interrupt.
// - Hardware sets a leaf status bit; software writing one clears it.
// - Leaf mask set forwards the error centrally; clear blocks forwarding.
// - Leaf status logs errors regardless of the leaf mask.
// - Streaming card-to-host leaf has status and mask registers.
// - Queue id of the first streaming error is captured and readable.
// - Card-to-host memory-mapped status: bit 16 direction, low bits error kind.
// - Host-to-card memory-mapped code flags read and write error kinds by bit.
// - Info registers hold queue id 28:17, direction 16, consumer index 15:0.
// - Request-queue leaf has status, mask and an access log register.
// - Double-bit ECC status flags one internal RAM per bit.
// - Double-bit ECC mask enables sources at the same bit positions.
// - Single-bit ECC status flags correctable errors, same positions.
// - Single-bit ECC mask enables sources at the same bit positions.
// - Streaming fatal errors logged; fatal mask routes them to fatal handling.
// - Fatal enable separately stops write requests and inverts payload parity.
// - Parity passes through unchanged unless fatal enable inverts it; bridge slave double-bit errors flag parity.
// - Aggregated error raises the interrupt only while armed; taking disarms.
// - Reset leaves leaf status bits alone, only write-one clears them; reset and any nonzero write clear memory-mapped status.
module eag_error_aggregator #(
    parameter int QID_W = eag_pkg::QID_W,
    parameter int PAR_W = eag_pkg::PAR_W
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic [31:0] eccSingleEvent,
    input wire logic [31:0] eccDoubleEvent,
    input wire logic [31:0] rqErrEvent,
    input wire logic [31:0] rqErrLog,
    input wire logic [31:0] streamErrEvent,
    input wire logic [QID_W-1:0] streamErrQid,
    input wire logic [31:0] fatalErrEvent,
    input wire logic mmC2hErr,
    input wire logic mmC2hWrite,
    input wire logic [31:0] mmC2hCode,
    input wire logic [11:0] mmC2hQid,
    input wire logic mmC2hDir,
    input wire logic [15:0] mmC2hCidx,
    input wire logic mmH2cErr,
    input wire logic mmH2cWrite,
    input wire logic [31:0] mmH2cCode,
    input wire logic [11:0] mmH2cQid,
    input wire logic mmH2cDir,
    input wire logic [15:0] mmH2cCidx,
    input wire logic [PAR_W-1:0] payloadParityIn,
    output logic [PAR_W-1:0] payloadParityOut,
    output logic bridgeParityErr,
    output logic writeRequestDisable,
    output logic payloadParityInvert,
    output logic errIrq
);
    eag_leaf_if #(.W(32)) sbIf ();
    eag_leaf_if #(.W(32)) dbIf ();
    eag_leaf_if #(.W(32)) rqIf ();
    eag_leaf_if #(.W(32)) stIf ();
    eag_leaf_if #(.W(32)) ftIf ();

    eag_leaf #(.W(32), .VALID(eag_pkg::ECC_VALID)) u_ecc_sb (
        .core_clk(core_clk), .reset(reset), .lp(sbIf.leaf));
    eag_leaf #(.W(32), .VALID(eag_pkg::ECC_VALID)) u_ecc_db (
        .core_clk(core_clk), .reset(reset), .lp(dbIf.leaf));
    eag_leaf #(.W(32), .VALID(eag_pkg::ALL_VALID)) u_rq (
        .core_clk(core_clk), .reset(reset), .lp(rqIf.leaf));
    eag_leaf #(.W(32), .VALID(eag_pkg::ALL_VALID)) u_stream (
        .core_clk(core_clk), .reset(reset), .lp(stIf.leaf));
    eag_leaf #(.W(32), .VALID(eag_pkg::ALL_VALID)) u_fatal (
        .core_clk(core_clk), .reset(reset), .lp(ftIf.leaf));

    // Bus request decode; writes commit on the edge that ends the ack cycle
    logic req;
    logic wrHit;
    logic [15:0] regAdr;
    logic [31:0] bm;
    logic [31:0] wd;

    assign req = cyc_i & stb_i;
    assign wrHit = req & we_i & ack_o;
    assign regAdr = {adr_i[15:2], 2'b00};
    assign bm = eag_pkg::byte_mask(sel_i);
    assign wd = dat_i & bm;

    function automatic logic [31:0] merge(input logic [31:0] old);
        return wd | (old & ~bm);
    endfunction

    function automatic logic hit(input logic [15:0] ofs);
        return wrHit && (regAdr == ofs);
    endfunction

    assign sbIf.errEvent = eccSingleEvent;
    assign dbIf.errEvent = eccDoubleEvent;
    assign rqIf.errEvent = rqErrEvent;
    assign stIf.errEvent = streamErrEvent;
    assign ftIf.errEvent = fatalErrEvent;

    always_comb sbIf.clearBits = hit(eag_pkg::OFS_ECC_SB_STATUS) ? wd : '0;
    always_comb dbIf.clearBits = hit(eag_pkg::OFS_ECC_DB_STATUS) ? wd : '0;
    always_comb rqIf.clearBits = hit(eag_pkg::OFS_RQ_STATUS) ? wd : '0;
    always_comb stIf.clearBits = hit(eag_pkg::OFS_STREAM_STATUS) ? wd : '0;
    always_comb ftIf.clearBits = hit(eag_pkg::OFS_FATAL_STATUS) ? wd : '0;

    always_comb sbIf.maskWe = hit(eag_pkg::OFS_ECC_SB_MASK);
    always_comb dbIf.maskWe = hit(eag_pkg::OFS_ECC_DB_MASK);
    always_comb rqIf.maskWe = hit(eag_pkg::OFS_RQ_MASK);
    always_comb stIf.maskWe = hit(eag_pkg::OFS_STREAM_MASK);
    always_comb ftIf.maskWe = hit(eag_pkg::OFS_FATAL_MASK);

    always_comb sbIf.maskData = merge(sbIf.mask);
    always_comb dbIf.maskData = merge(dbIf.mask);
    always_comb rqIf.maskData = merge(rqIf.mask);
    always_comb stIf.maskData = merge(stIf.mask);
    always_comb ftIf.maskData = merge(ftIf.mask);

    // Memory-mapped detail registers, index 0 card-to-host, 1 host-to-card
    logic [1:0] mmErr;
    logic [1:0] mmWrite;
    logic [31:0] mmCodeIn [2];
    logic [31:0] mmInfoIn [2];
    logic [1:0] mmClear;
    logic [31:0] mmStatus [2];
    logic [31:0] mmCode [2];
    logic [31:0] mmInfo [2];
    logic [31:0] next_mmStatus [2];
    logic [31:0] next_mmCode [2];
    logic [31:0] next_mmInfo [2];

    assign mmErr = {mmH2cErr, mmC2hErr};
    assign mmWrite = {mmH2cWrite, mmC2hWrite};
    assign mmCodeIn[0] = eag_pkg::mm_code(mmC2hWrite, mmC2hCode,
        eag_pkg::C2H_WR_CODES, eag_pkg::C2H_RD_CODES);
    assign mmCodeIn[1] = eag_pkg::mm_code(mmH2cWrite, mmH2cCode,
        eag_pkg::H2C_WR_CODES, eag_pkg::H2C_RD_CODES);
    assign mmInfoIn[0] = eag_pkg::mm_info(mmC2hQid, mmC2hDir, mmC2hCidx);
    assign mmInfoIn[1] = eag_pkg::mm_info(mmH2cQid, mmH2cDir, mmH2cCidx);
    always_comb mmClear[0] = hit(eag_pkg::OFS_MM_C2H_STATUS) && (wd != eag_pkg::RESET_ZERO);
    always_comb mmClear[1] = hit(eag_pkg::OFS_MM_H2C_STATUS) && (wd != eag_pkg::RESET_ZERO);

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_mmStatus[i] = mmStatus[i];
            next_mmCode[i] = mmCode[i];
            next_mmInfo[i] = mmInfo[i];
            if (mmErr[i]) begin
                next_mmStatus[i] = eag_pkg::RESET_ZERO;
                next_mmStatus[i][eag_pkg::MM_DIR_BIT] = mmWrite[i];
                next_mmStatus[i][eag_pkg::MM_CODE_MSB:0] = mmCodeIn[i][eag_pkg::MM_CODE_MSB:0];
                next_mmCode[i] = mmCodeIn[i];
                next_mmInfo[i] = mmInfoIn[i];
            end else if (mmClear[i]) begin
                next_mmStatus[i] = eag_pkg::RESET_ZERO;
                next_mmCode[i] = eag_pkg::RESET_ZERO;
                next_mmInfo[i] = eag_pkg::RESET_ZERO;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) begin
                mmStatus[i] <= eag_pkg::RESET_ZERO;
                mmCode[i] <= eag_pkg::RESET_ZERO;
                mmInfo[i] <= eag_pkg::RESET_ZERO;
            end else begin
                mmStatus[i] <= next_mmStatus[i];
                mmCode[i] <= next_mmCode[i];
                mmInfo[i] <= next_mmInfo[i];
            end
        end
    end

    // Central aggregation, first-error capture and request-queue log
    logic [31:0] centralStatus;
    logic [31:0] centralMask;
    logic [31:0] fatalEnable;
    logic [31:0] rqLog;
    logic [QID_W-1:0] firstQid;
    logic qidHeld;
    logic arm;
    logic aggErr;
    logic fire;
    logic ctrlWe;
    logic streamNew;
    logic [31:0] next_centralMask;
    logic [31:0] next_fatalEnable;
    logic [31:0] next_rqLog;
    logic [QID_W-1:0] next_firstQid;
    logic next_qidHeld;
    logic next_arm;

    always_comb begin
        centralStatus = eag_pkg::RESET_ZERO;
        centralStatus[eag_pkg::LEAF_ECC_SB] = sbIf.forward;
        centralStatus[eag_pkg::LEAF_ECC_DB] = dbIf.forward;
        centralStatus[eag_pkg::LEAF_RQ] = rqIf.forward;
        centralStatus[eag_pkg::LEAF_STREAM] = stIf.forward;
        centralStatus[eag_pkg::LEAF_MM_C2H] = |mmCode[0];
        centralStatus[eag_pkg::LEAF_MM_H2C] = |mmCode[1];
    end

    assign aggErr = |(centralStatus & centralMask);
    always_comb ctrlWe = hit(eag_pkg::OFS_ERR_INT_CTRL);
    assign fire = aggErr & arm & ~ctrlWe;
    assign streamNew = |streamErrEvent;

    always_comb begin
        next_centralMask = hit(eag_pkg::OFS_CENTRAL_MASK) ? merge(centralMask) : centralMask;
        next_fatalEnable = hit(eag_pkg::OFS_FATAL_ENABLE) ? merge(fatalEnable) : fatalEnable;
        next_rqLog = (|(rqErrEvent)) ? rqErrLog : rqLog;
        next_firstQid = firstQid;
        next_qidHeld = qidHeld;
        if (streamNew && !qidHeld) begin
            next_firstQid = streamErrQid;
            next_qidHeld = 1'b1;
        end else if (!streamNew && stIf.status == eag_pkg::RESET_ZERO) begin
            next_qidHeld = 1'b0;
        end
        next_arm = arm;
        if (ctrlWe && sel_i[0]) begin
            next_arm = dat_i[eag_pkg::ARM_BIT];
        end else if (fire) begin
            next_arm = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            centralMask <= eag_pkg::RESET_ZERO;
            fatalEnable <= eag_pkg::RESET_ZERO;
            rqLog <= eag_pkg::RESET_ZERO;
            firstQid <= '0;
            qidHeld <= 1'b0;
            arm <= 1'b0;
        end else begin
            centralMask <= next_centralMask;
            fatalEnable <= next_fatalEnable;
            rqLog <= next_rqLog;
            firstQid <= next_firstQid;
            qidHeld <= next_qidHeld;
            arm <= next_arm;
        end
    end

    // Fatal handling and parity pass-through
    logic next_stop;
    logic next_invert;
    logic [PAR_W-1:0] next_parity;
    logic next_bridgeParity;

    always_comb begin
        next_stop = ftIf.forward & fatalEnable[eag_pkg::FATAL_STOP_BIT];
        next_invert = ftIf.forward & fatalEnable[eag_pkg::FATAL_PARITY_BIT];
        next_parity = payloadParityIn ^ {PAR_W{next_invert}};
        next_bridgeParity = |(eccDoubleEvent & eag_pkg::ECC_BRIDGE_SLAVE);
    end

    // Read mux and bus response
    logic [31:0] rdMux;
    logic next_ack;
    logic [31:0] next_datOut;

    always_comb begin
        case (regAdr)
            eag_pkg::OFS_ECC_SB_MASK: rdMux = sbIf.mask;
            eag_pkg::OFS_ECC_SB_STATUS: rdMux = sbIf.status;
            eag_pkg::OFS_ECC_DB_MASK: rdMux = dbIf.mask;
            eag_pkg::OFS_ECC_DB_STATUS: rdMux = dbIf.status;
            eag_pkg::OFS_CENTRAL_STATUS: rdMux = centralStatus;
            eag_pkg::OFS_CENTRAL_MASK: rdMux = centralMask;
            eag_pkg::OFS_RQ_STATUS: rdMux = rqIf.status;
            eag_pkg::OFS_RQ_MASK: rdMux = rqIf.mask;
            eag_pkg::OFS_RQ_LOG: rdMux = rqLog;
            eag_pkg::OFS_ERR_INT_CTRL: rdMux = {31'h0000_0000, arm};
            eag_pkg::OFS_STREAM_STATUS: rdMux = stIf.status;
            eag_pkg::OFS_STREAM_MASK: rdMux = stIf.mask;
            eag_pkg::OFS_FATAL_STATUS: rdMux = ftIf.status;
            eag_pkg::OFS_FATAL_MASK: rdMux = ftIf.mask;
            eag_pkg::OFS_FATAL_ENABLE: rdMux = fatalEnable;
            eag_pkg::OFS_FIRST_QID: rdMux = {{(32-QID_W){1'b0}}, firstQid};
            eag_pkg::OFS_MM_C2H_STATUS: rdMux = mmStatus[0];
            eag_pkg::OFS_MM_C2H_CODE: rdMux = mmCode[0];
            eag_pkg::OFS_MM_C2H_INFO: rdMux = mmInfo[0];
            eag_pkg::OFS_MM_H2C_STATUS: rdMux = mmStatus[1];
            eag_pkg::OFS_MM_H2C_CODE: rdMux = mmCode[1];
            eag_pkg::OFS_MM_H2C_INFO: rdMux = mmInfo[1];
            default: rdMux = eag_pkg::RESET_ZERO;
        endcase
        next_ack = req & ~ack_o;
        next_datOut = (req & ~ack_o & ~we_i) ? rdMux : eag_pkg::RESET_ZERO;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            ack_o <= 1'b0;
            dat_o <= eag_pkg::RESET_ZERO;
            errIrq <= 1'b0;
            writeRequestDisable <= 1'b0;
            payloadParityInvert <= 1'b0;
            payloadParityOut <= '0;
            bridgeParityErr <= 1'b0;
        end else begin
            ack_o <= next_ack;
            dat_o <= next_datOut;
            errIrq <= fire;
            writeRequestDisable <= next_stop;
            payloadParityInvert <= next_invert;
            payloadParityOut <= next_parity;
            bridgeParityErr <= next_bridgeParity;
        end
    end

    property p_irq_take;
        @(posedge core_clk) disable iff (reset)
            (aggErr && arm && !ctrlWe) |=> (errIrq && !arm);
    endproperty
    a_irq_take: assert property (p_irq_take) else $error("armed error not taken");

    property p_irq_cause;
        @(posedge core_clk) disable iff (reset)
            errIrq |-> ($past(arm) && $past(aggErr));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

    property p_first_qid;
        @(posedge core_clk) disable iff (reset)
            (streamNew && !qidHeld) |=> (qidHeld && firstQid == $past(streamErrQid));
    endproperty
    a_first_qid: assert property (p_first_qid) else $error("first queue id missed");

    property p_fatal_stop;
        @(posedge core_clk) disable iff (reset)
            (ftIf.forward && fatalEnable[eag_pkg::FATAL_STOP_BIT]) |=> writeRequestDisable;
    endproperty
    a_fatal_stop: assert property (p_fatal_stop) else $error("fatal stop not applied");

    property p_parity_pass;
        @(posedge core_clk) disable iff (reset)
            (!fatalEnable[eag_pkg::FATAL_PARITY_BIT]) [*2] |->
                payloadParityOut == $past(payloadParityIn);
    endproperty
    a_parity_pass: assert property (p_parity_pass) else $error("parity altered");

    property p_mm_capture;
        @(posedge core_clk) disable iff (reset)
            mmC2hErr |=> (mmInfo[0][eag_pkg::MM_QID_MSB:eag_pkg::MM_QID_LSB] == $past(mmC2hQid)
                && mmStatus[0][eag_pkg::MM_DIR_BIT] == $past(mmC2hWrite));
    endproperty
    a_mm_capture: assert property (p_mm_capture) else $error("mm detail not captured");
endmodule

// *** testbench/tb_top.sv ***
// Register-level bench for the error aggregator
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 0, reset = 1, cyc_i, stb_i, we_i, ack_o;
    logic [31:0] dat_i, dat_o, eccSingleEvent, eccDoubleEvent, rqErrEvent, rqErrLog, q;
    logic [31:0] streamErrEvent, fatalErrEvent, mmC2hCode, mmH2cCode;
    logic [11:0] streamErrQid, mmC2hQid, mmH2cQid;
    logic [15:0] adr_i, mmC2hCidx, mmH2cCidx;
    logic [7:0] payloadParityIn, payloadParityOut;
    logic [3:0] sel_i;
    logic mmC2hErr, mmC2hWrite, mmC2hDir, mmH2cErr, mmH2cWrite, mmH2cDir;
    logic bridgeParityErr, writeRequestDisable, payloadParityInvert, errIrq;
    int error_cnt = 0, n_compared = 0;
    always #4 core_clk = ~core_clk;
    eag_error_aggregator dut_u (.core_clk, .reset, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .eccSingleEvent, .eccDoubleEvent, .rqErrEvent, .rqErrLog,
        .streamErrEvent, .streamErrQid, .fatalErrEvent, .mmC2hErr, .mmC2hWrite, .mmC2hCode,
        .mmC2hQid, .mmC2hDir, .mmC2hCidx, .mmH2cErr, .mmH2cWrite, .mmH2cCode, .mmH2cQid,
        .mmH2cDir, .mmH2cCidx, .payloadParityIn, .payloadParityOut, .bridgeParityErr,
        .writeRequestDisable, .payloadParityInvert, .errIrq);
    task test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        @(posedge core_clk);
        while (ack_o !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                $display("[FAIL] %0t bus timeout", $time);
                test_done();
            end
            @(posedge core_clk);
        end
        q = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        @(posedge core_clk);
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        acc(1, a, d);
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e);
        acc(0, a, 32'h0);
        chk(q, e);
    endtask
    task irqs(input int e);
        int c;
        c = 0;
        repeat (8) begin
            @(posedge core_clk);
            if (errIrq === 1'b1) c++;
        end
        chk(32'(c), 32'(e));
    endtask
    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, eccSingleEvent, eccDoubleEvent} = '0;
        {rqErrEvent, rqErrLog, streamErrEvent, streamErrQid, fatalErrEvent} = '0;
        {mmC2hErr, mmC2hWrite, mmC2hCode, mmC2hQid, mmC2hDir, mmC2hCidx} = '0;
        {mmH2cErr, mmH2cWrite, mmH2cCode, mmH2cQid, mmH2cDir, mmH2cCidx} = '0;
        payloadParityIn = 8'h5a;
        repeat (6) @(posedge core_clk);
        reset <= 0;
        wr(eag_pkg::OFS_STREAM_MASK, 32'h1);
        wr(eag_pkg::OFS_CENTRAL_MASK, 32'h8);
        wr(eag_pkg::OFS_ERR_INT_CTRL, 32'h1);
        streamErrEvent <= 32'h1; streamErrQid <= 12'h5a5;
        @(posedge core_clk);
        streamErrEvent <= 32'h0;
        irqs(1);
        rd(eag_pkg::OFS_CENTRAL_STATUS, 32'h8);
        rd(eag_pkg::OFS_FIRST_QID, 32'h5a5);
        streamErrEvent <= 32'h2; streamErrQid <= 12'h123;
        @(posedge core_clk);
        streamErrEvent <= 32'h0;
        irqs(0);
        rd(eag_pkg::OFS_STREAM_STATUS, 32'h3);
        wr(eag_pkg::OFS_STREAM_STATUS, 32'h1);
        rd(eag_pkg::OFS_STREAM_STATUS, 32'h2);
        rd(eag_pkg::OFS_CENTRAL_STATUS, 32'h0);
        rd(eag_pkg::OFS_FIRST_QID, 32'h5a5);
        reset <= 1;
        repeat (2) @(posedge core_clk);
        reset <= 0;
        rd(eag_pkg::OFS_STREAM_STATUS, 32'h2);
        rd(eag_pkg::OFS_STREAM_MASK, 32'h0);
        $display("stream test done");
        wr(eag_pkg::OFS_ECC_DB_MASK, 32'hffff_ffff);
        eccDoubleEvent <= 32'hffff_ffff; eccSingleEvent <= 32'h10;
        @(posedge core_clk);
        {eccDoubleEvent, eccSingleEvent} <= '0;
        @(posedge core_clk);
        chk(32'(bridgeParityErr), 32'h1);
        rd(eag_pkg::OFS_ECC_DB_STATUS, eag_pkg::ECC_VALID);
        rd(eag_pkg::OFS_ECC_SB_STATUS, 32'h10);
        rd(eag_pkg::OFS_CENTRAL_STATUS, 32'h2);
        $display("ecc test done");
        wr(eag_pkg::OFS_FATAL_MASK, 32'h1);
        wr(eag_pkg::OFS_FATAL_ENABLE, 32'h3);
        fatalErrEvent <= 32'h1;
        @(posedge core_clk);
        fatalErrEvent <= 32'h0;
        repeat (4) @(posedge core_clk);
        chk({writeRequestDisable, payloadParityInvert, payloadParityOut}, 32'h3a5);
        rd(eag_pkg::OFS_FATAL_STATUS, 32'h1);
        $display("fatal test done");
        {mmC2hErr, mmC2hWrite, mmC2hCode, mmC2hQid, mmC2hDir} <= {2'b11, 32'hf, 12'habc, 1'b1};
        {mmH2cErr, mmH2cCode, rqErrEvent, rqErrLog} <= {1'b1, 32'hffff_ffff, 32'h1, 32'hbeef};
        mmC2hCidx <= 16'h1234;
        @(posedge core_clk);
        {mmC2hErr, mmH2cErr, rqErrEvent} <= '0;
        rd(eag_pkg::OFS_MM_C2H_STATUS, 32'h1_0007);
        rd(eag_pkg::OFS_MM_C2H_INFO, {3'h0, 12'habc, 1'b1, 16'h1234});
        rd(eag_pkg::OFS_MM_H2C_CODE, 32'h0041_013e);
        rd(eag_pkg::OFS_RQ_LOG, 32'hbeef);
        rd(16'h0004, 32'h0);
        $display("detail test done");
        test_done();
    end
endmodule
